// File: fctm_monitor.sv
// Fieldbus control timeout monitor with its AXI4-Lite register slave.
// Assumes all inputs synchronous to aclk; update strobes are one-cycle.
`timescale 1ns/10ps

module fctm_monitor
#(
    // Clocks per tenth of a second; only a bench should shorten it
    parameter int TICKS_PER_TENTH = fctm_pkg::TENTH_CYCLES
)
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Network input update strobes
    input  wire logic        net_in_start_stop,
    input  wire logic        net_in_fault_reset,
    input  wire logic        net_in_control_word,
    input  wire logic        net_in_speed_setpoint,
    input  wire logic        net_in_reference_percent,
    input  wire logic        net_in_reference_hertz,
    // Drive setup and actions
    input  wire logic [1:0]  active_setup,
    output logic [1:0]       setup_select,
    output logic             setup_override,
    output logic [4:0]       action_active,
    output logic             action_pulse,
    output logic             timeout_warning,
    output logic             irq
);
    import fctm_pkg::*;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [17:0] timeout;
        logic [4:0]  action;
        logic        policy;
        logic        reset_to;
        logic        alt_proto;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic [23:0] tick_cnt;
        logic [17:0] tenth_cnt;
        fctm_state_t state;
        logic [1:0]  orig_setup;
        logic [1:0]  setup_sel;
        logic        override;
        logic [4:0]  act_active;
        logic        act_pulse;
        logic        warn;
        logic        irq;
    } fctm_regs_t;

    fctm_regs_t r_reg;
    fctm_regs_t r_next;

    logic       update_any;
    logic       is_setup_act;
    logic       wr_fire;
    logic       wr_ok;
    logic       expire;
    logic [2:0] ev;

    always_comb
    begin
        r_next = r_reg;
        ev     = 3'h0;
        wr_ok  = 1'b1;
        // Any refresh from the controller restarts the interval
        update_any = net_in_start_stop | net_in_fault_reset | net_in_control_word
                   | net_in_speed_setpoint | net_in_reference_percent
                   | net_in_reference_hertz;
        is_setup_act = (r_reg.action >= ACT_SETUP1) && (r_reg.action <= ACT_SETUP4);

        // Write address and data may arrive in either order
        if (s_axi_awvalid && r_reg.awready)
        begin
            r_next.aw_got  = 1'b1;
            r_next.aw_addr = s_axi_awaddr;
            r_next.awready = 1'b0;
        end
        if (s_axi_wvalid && r_reg.wready)
        begin
            r_next.w_got  = 1'b1;
            r_next.w_data = s_axi_wdata;
            r_next.wready = 1'b0;
        end
        wr_fire = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;

        // Self-clearing reset setting: one cycle wide when written
        r_next.reset_to = 1'b0;

        if (wr_fire)
        begin
            unique case (r_reg.aw_addr)
                ADDR_TIMEOUT:
                    // Out-of-range interval refused, old value kept
                    if (r_reg.w_data[17:0] >= TIMEOUT_MIN
                        && r_reg.w_data[17:0] <= TIMEOUT_MAX
                        && r_reg.w_data[31:18] == 14'h0)
                        r_next.timeout = r_reg.w_data[17:0];
                    else
                        wr_ok = 1'b0;
                ADDR_ACTION:
                    // Only documented codes; override release needs alt protocol
                    if (r_reg.w_data[31:5] == 27'h0
                        && (r_reg.w_data[4:0] <= ACT_STOP_TRIP
                            || (r_reg.w_data[4:0] >= ACT_SETUP1
                                && r_reg.w_data[4:0] <= ACT_SETUP4)
                            || (r_reg.w_data[4:0] == ACT_OVR_REL && r_reg.alt_proto)))
                        r_next.action = r_reg.w_data[4:0];
                    else
                        wr_ok = 1'b0;
                ADDR_POLICY:
                    r_next.policy = r_reg.w_data[0];
                ADDR_RESET_TO:
                    r_next.reset_to = r_reg.w_data[0];
                ADDR_CONFIG:
                    r_next.alt_proto = r_reg.w_data[0];
                ADDR_IRQ_MASK:
                    r_next.irq_mask = r_reg.w_data[2:0];
                default:
                    wr_ok = 1'b0;
            endcase
            // Dropping protocol invalidates a stored override release
            if (r_reg.aw_addr == ADDR_CONFIG && !r_reg.w_data[0]
                && r_reg.action == ACT_OVR_REL)
                r_next.action = ACT_OFF;
            r_next.bvalid  = 1'b1;
            r_next.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
            r_next.aw_got  = 1'b0;
            r_next.w_got   = 1'b0;
        end
        if (r_reg.bvalid && s_axi_bready)
        begin
            r_next.bvalid  = 1'b0;
            r_next.awready = 1'b1;
            r_next.wready  = 1'b1;
        end

        // Interval timer in tenths of a second
        expire = 1'b0;
        r_next.act_pulse = 1'b0;
        if (update_any)
        begin
            r_next.tick_cnt  = 24'h0;
            r_next.tenth_cnt = 18'h0;
        end
        else if (r_reg.state == FCTM_RUN)
        begin
            if (r_reg.tick_cnt == 24'(TICKS_PER_TENTH - 1))
            begin
                r_next.tick_cnt  = 24'h0;
                r_next.tenth_cnt = r_reg.tenth_cnt + 18'h1;
                if (r_reg.tenth_cnt + 18'h1 >= r_reg.timeout)
                    expire = 1'b1;
            end
            else
                r_next.tick_cnt = r_reg.tick_cnt + 24'h1;
        end

        unique case (r_reg.state)
            FCTM_RUN:
                if (expire && r_reg.action != ACT_OFF)
                begin
                    // Fire once; timer halts until the monitor is back in FCTM_RUN
                    r_next.state      = FCTM_LOST;
                    r_next.act_active = r_reg.action;
                    r_next.act_pulse  = 1'b1;
                    ev[EV_TIMEOUT]    = 1'b1;
                    if (is_setup_act)
                    begin
                        r_next.orig_setup = active_setup;
                        r_next.setup_sel  = 2'(r_reg.action - ACT_SETUP1);
                        r_next.override   = 1'b1;
                    end
                end
                else if (expire)
                    r_next.tenth_cnt = 18'h0;
            FCTM_LOST:
                if (update_any)
                begin
                    // Non-setup actions end on any qualifying update
                    ev[EV_RECOVER] = 1'b1;
                    if (!r_reg.override)
                    begin
                        r_next.state      = FCTM_RUN;
                        r_next.act_active = ACT_OFF;
                    end
                    else if (net_in_control_word)
                    begin
                        r_next.act_active = ACT_OFF;
                        // Policy only consulted for setup switches
                        if (r_reg.policy == POL_RESUME)
                        begin
                            r_next.state     = FCTM_RUN;
                            r_next.setup_sel = r_reg.orig_setup;
                            r_next.override  = 1'b0;
                        end
                        else
                        begin
                            r_next.state = FCTM_HOLD;
                            r_next.warn  = 1'b1;
                        end
                    end
                    else
                        ev[EV_RECOVER] = 1'b0;
                end
            FCTM_HOLD:
                if (r_reg.reset_to)
                begin
                    // Toggle of reset setting ends the hold
                    r_next.state     = FCTM_RUN;
                    r_next.setup_sel = r_reg.orig_setup;
                    r_next.override  = 1'b0;
                    r_next.warn      = 1'b0;
                end
        endcase

        // AXI4-Lite read; interrupt status read clears sticky bits, new events win
        if (s_axi_arvalid && r_reg.arready)
        begin
            r_next.arready = 1'b0;
            r_next.rvalid  = 1'b1;
            r_next.rresp   = RESP_OKAY;
            r_next.rdata   = 32'h0;
            unique case (s_axi_araddr)
                ADDR_TIMEOUT:  r_next.rdata[17:0] = r_reg.timeout;
                ADDR_ACTION:   r_next.rdata[4:0]  = r_reg.action;
                ADDR_POLICY:   r_next.rdata[0]    = r_reg.policy;
                ADDR_RESET_TO: r_next.rdata[0]    = r_reg.reset_to;
                ADDR_CONFIG:   r_next.rdata[0]    = r_reg.alt_proto;
                ADDR_STATUS:
                begin
                    r_next.rdata[1:0]    = r_reg.state;
                    r_next.rdata[ST_LOST] = (r_reg.state != FCTM_RUN);
                    r_next.rdata[ST_WARN] = r_reg.warn;
                end
                ADDR_IRQ_STAT:
                begin
                    r_next.rdata[2:0] = r_reg.irq_stat;
                    r_next.irq_stat   = 3'h0;
                end
                ADDR_IRQ_MASK: r_next.rdata[2:0]  = r_reg.irq_mask;
                ADDR_SETUP:    r_next.rdata[1:0]  = r_reg.setup_sel;
                default:       r_next.rresp       = RESP_SLVERR;
            endcase
        end
        if (r_reg.rvalid && s_axi_rready)
        begin
            r_next.rvalid  = 1'b0;
            r_next.arready = 1'b1;
        end

        ev[EV_REJECT]   = wr_fire && !wr_ok;
        r_next.irq_stat = r_next.irq_stat | ev;
        r_next.irq      = |(r_next.irq_stat & r_next.irq_mask);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r_reg            <= '0;
            r_reg.awready    <= 1'b1;
            r_reg.wready     <= 1'b1;
            r_reg.arready    <= 1'b1;
            r_reg.timeout    <= TIMEOUT_RST;
            r_reg.action     <= ACT_OFF;
            r_reg.policy     <= POL_RESUME;
            r_reg.setup_sel  <= SETUP_RST;
            r_reg.orig_setup <= SETUP_RST;
            r_reg.state      <= FCTM_RUN;
        end
        else
            r_reg <= r_next;
    end

    assign s_axi_awready   = r_reg.awready;
    assign s_axi_wready    = r_reg.wready;
    assign s_axi_bvalid    = r_reg.bvalid;
    assign s_axi_bresp     = r_reg.bresp;
    assign s_axi_arready   = r_reg.arready;
    assign s_axi_rvalid    = r_reg.rvalid;
    assign s_axi_rresp     = r_reg.rresp;
    assign s_axi_rdata     = r_reg.rdata;
    assign setup_select    = r_reg.setup_sel;
    assign setup_override  = r_reg.override;
    assign action_active   = r_reg.act_active;
    assign action_pulse    = r_reg.act_pulse;
    assign timeout_warning = r_reg.warn;
    assign irq             = r_reg.irq;

endmodule : fctm_monitor

// File: fctm_monitor_asserts.sv
// Port checker for the fieldbus control timeout monitor.
// Assumes it is bound into fctm_monitor; one aclk domain.
`timescale 1ns/10ps
module fctm_monitor_asserts
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes
    input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic        s_axi_rvalid, s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [31:0] s_axi_rdata,
    // Drive side
    input wire logic [1:0]  setup_select,
    input wire logic        setup_override, action_pulse, timeout_warning, irq,
    input wire logic [4:0]  action_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_pulse_once; action_pulse |=> !action_pulse; endproperty
    a_pulse_once: assert property (p_pulse_once) else $error("action pulse repeated");
    property p_pulse_code; action_pulse |-> action_active != 5'h00; endproperty
    a_pulse_code: assert property (p_pulse_code) else $error("pulse without action");
    property p_warn; timeout_warning |-> setup_override; endproperty
    a_warn: assert property (p_warn) else $error("warning without fallback setup");
    property p_setup_sw;
        action_pulse && action_active >= 5'h07 && action_active <= 5'h0a
            |-> setup_override && setup_select == 2'(action_active - 5'h07);
    endproperty
    a_setup_sw: assert property (p_setup_sw) else $error("setup switch wrong");
    property p_reset;
        $rose(aresetn) |-> !action_pulse && !irq && setup_select == 2'h0 && !s_axi_bvalid;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not idle after reset");
    property p_wr_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write response late");
    property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule : fctm_monitor_asserts

bind fctm_monitor fctm_monitor_asserts fctm_monitor_asserts_i (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_bresp, .s_axi_rdata, .setup_select, .setup_override, .action_pulse,
    .timeout_warning, .irq, .action_active);

// File: fctm_monitor_tb.sv
// Self-checking bench for the fieldbus control timeout monitor.
// Assumes fctm_pkg, the checker bind and the remote controller model.
`timescale 1ns/10ps
module fctm_monitor_tb;
    import fctm_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, setup_override, action_pulse, timeout_warning, irq, net_en;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, v, aexp, texp;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, active_setup, setup_select, r, s;
    logic [4:0]  action_active;
    logic [5:0]  net;
    int          error_cnt = 0, cmp_count = 0, cycles = 0, seed, i, alt, upd_cyc = 0;
    int          bnd [4] = '{9, 10, 180000, 180001};
    // Short tenth so a 1.0 s interval fits the run; refresh gaps stay below it
    localparam int TB_TENTH = 10;

    fctm_monitor #(.TICKS_PER_TENTH(TB_TENTH)) fctm_monitor_i (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .net_in_start_stop(net[0]), .net_in_fault_reset(net[1]),
        .net_in_control_word(net[2]), .net_in_speed_setpoint(net[3]),
        .net_in_reference_percent(net[4]), .net_in_reference_hertz(net[5]),
        .active_setup, .setup_select, .setup_override, .action_active, .action_pulse,
        .timeout_warning, .irq);
    fctm_remote_ctrl fctm_remote_ctrl_i (.aclk, .aresetn, .enable(net_en), .net_in(net));

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Hang guard, far above the few thousand cycles the tests need
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (|net)
            upd_cyc <= cycles;
        if (cycles == 30000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task end_sim();
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // Address and data offered together, each dropped at its own ready
    task wr(input logic [7:0] a, input logic [31:0] val);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_bready <= 1'b1;
        s_axi_wdata <= val; s_axi_wvalid <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (aw && s_axi_awready === 1'b1) begin aw = 1'b0; s_axi_awvalid <= 1'b0; end
            if (w && s_axi_wready === 1'b1) begin w = 1'b0; s_axi_wvalid <= 1'b0; end
            if (s_axi_bvalid === 1'b1) begin r = s_axi_bresp; s_axi_bready <= 1'b0; break; end
        end
    endtask : wr
    task rd(input logic [7:0] a);
        logic ar;
        ar = 1'b1;
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (ar && s_axi_arready === 1'b1) begin ar = 1'b0; s_axi_arvalid <= 1'b0; end
            if (s_axi_rvalid === 1'b1)
            begin
                d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0; break;
            end
        end
    endtask : rd
    function automatic logic act_ok(input int c, input int en_alt);
        return c <= 5 || (c >= 7 && c <= 10) || (en_alt == 1 && c == 20);
    endfunction : act_ok
    function automatic logic to_ok(input logic [31:0] t);
        return t >= 32'd10 && t <= 32'd180000;
    endfunction : to_ok

    initial
    begin
        seed = 15881;
        aresetn = 1'b0; net_en = 1'b0; s_axi_wstrb = 4'hf; active_setup = 2'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        net_en <= 1'b1;
        rd(ADDR_TIMEOUT); chk(d, 32'h258);
        rd(ADDR_ACTION); chk(d, 32'h0);
        rd(ADDR_POLICY); chk(d, 32'h1);
        rd(ADDR_RESET_TO); chk(d, 32'h0);
        $display("Test reset values ended");
        texp = 32'h258;
        for (i = 0; i < 12; i++)
        begin
            v = (i < 4) ? bnd[i] : $unsigned($random(seed)) % 190000;
            wr(ADDR_TIMEOUT, v); chk(r, to_ok(v) ? RESP_OKAY : RESP_SLVERR);
            if (to_ok(v)) texp = v;
            rd(ADDR_TIMEOUT); chk(d, texp);
        end
        $display("Test timeout range ended");
        aexp = 32'h0;
        for (alt = 0; alt < 2; alt++)
        begin
            wr(ADDR_CONFIG, alt);
            for (i = 0; i < 32; i++)
            begin
                active_setup <= 2'($random(seed));
                wr(ADDR_ACTION, i); chk(r, act_ok(i, alt) ? RESP_OKAY : RESP_SLVERR);
                if (act_ok(i, alt)) aexp = i;
                rd(ADDR_ACTION); chk(d, aexp);
            end
        end
        wr(ADDR_CONFIG, 32'h0); rd(ADDR_ACTION); chk(d, 32'h0);
        $display("Test action codes ended");
        wr(ADDR_RESET_TO, 32'h1); chk(r, RESP_OKAY);
        rd(ADDR_RESET_TO); chk(d, 32'h0);
        wr(ADDR_POLICY, 32'h0); rd(ADDR_POLICY); chk(d, 32'h0);
        rd(ADDR_SETUP); chk(d, 32'h0);
        chk({31'h0, setup_override}, 32'h0);
        $display("Test policy and reset setting ended");
        rd(ADDR_IRQ_STAT);
        wr(ADDR_IRQ_MASK, 32'h4); wr(ADDR_TIMEOUT, 32'h0);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        rd(ADDR_IRQ_STAT); chk(d, 32'h4);
        rd(ADDR_IRQ_STAT); chk(d, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h0); wr(ADDR_TIMEOUT, 32'h0);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        wr(8'h40, 32'h1); chk(r, RESP_SLVERR);
        rd(8'h40); chk(r, RESP_SLVERR);
        $display("Test interrupt and unmapped ended");
        wr(ADDR_TIMEOUT, 32'd10); wr(ADDR_IRQ_MASK, 32'h1); rd(ADDR_IRQ_STAT);
        for (i = 0; i < 3; i++)
        begin
            // Stop first, then a setup switch under resume and under hold
            v = (i == 0) ? 32'd2 : 32'd7 + ($unsigned($random(seed)) % 4);
            s = 2'($random(seed));
            active_setup <= s;
            wr(ADDR_ACTION, v); wr(ADDR_POLICY, {31'h0, i != 2});
            net_en <= 1'b0;
            while (action_pulse !== 1'b1)
                @(posedge aclk);
            chk(cycles - upd_cyc, 10 * TB_TENTH + 1);
            chk({31'h0, irq}, 32'h1);
            chk({27'h0, action_active}, v);
            texp = (v >= 7) ? 32'h4 + v - 32'h7 : 32'h0;
            chk({29'h0, setup_override, setup_select}, texp);
            rd(ADDR_STATUS); chk(d, 32'h5);
            rd(ADDR_IRQ_STAT); chk(d, 32'h1);
            repeat (300) @(posedge aclk);
            rd(ADDR_IRQ_STAT); chk(d, 32'h0);
            net_en <= 1'b1;
            // Start/stop and fault reset come first; only the control word ends a switch
            repeat (60) @(posedge aclk);
            chk({27'h0, action_active}, (v >= 7) ? v : 32'h0);
            repeat (90) @(posedge aclk);
            texp = (i == 0) ? 32'h0 : (i == 1) ? {30'h0, s} : 32'h4 + v - 32'h7;
            chk({29'h0, setup_override, setup_select}, texp);
            chk({31'h0, timeout_warning}, {31'h0, i == 2});
            rd(ADDR_STATUS); chk(d, (i == 2) ? 32'he : 32'h0);
            rd(ADDR_IRQ_STAT); chk(d, 32'h2);
        end
        wr(ADDR_RESET_TO, 32'h1); rd(ADDR_STATUS); chk(d, 32'h0);
        chk({28'h0, setup_override, setup_select, timeout_warning}, {29'h0, s, 1'b0});
        $display("Test timeout actions ended");
        repeat (400) @(posedge aclk);
        rd(ADDR_STATUS); chk(d, 32'h0);
        chk({27'h0, action_active}, 32'h0);
        $display("Test link refresh ended");
        end_sim();
    end
endmodule : fctm_monitor_tb

// File: fctm_pkg.sv
// Package for the fieldbus control timeout monitor: register map,
// field encodings, reset values and timing counts.
// Assumes a 100 MHz device clock and a 32-bit AXI4-Lite register bus.
package fctm_pkg;

    // Register byte offsets
    localparam logic [7:0]  ADDR_TIMEOUT   = 8'h00;
    localparam logic [7:0]  ADDR_ACTION    = 8'h04;
    localparam logic [7:0]  ADDR_POLICY    = 8'h08;
    localparam logic [7:0]  ADDR_RESET_TO  = 8'h0c;
    localparam logic [7:0]  ADDR_CONFIG    = 8'h10;
    localparam logic [7:0]  ADDR_STATUS    = 8'h14;
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h18;
    localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h1c;
    localparam logic [7:0]  ADDR_SETUP     = 8'h20;

    // Timeout interval in tenths of a second
    localparam logic [17:0] TIMEOUT_MIN    = 18'h0000a;
    localparam logic [17:0] TIMEOUT_MAX    = 18'h2bf20;
    localparam logic [17:0] TIMEOUT_RST    = 18'h00258;
    localparam int          TENTH_NS       = 100_000_000;
    localparam int          CLK_NS         = 10;
    localparam int          TENTH_CYCLES   = TENTH_NS / CLK_NS;

    // Timeout action selector encodings
    localparam logic [4:0]  ACT_OFF        = 5'h00;
    localparam logic [4:0]  ACT_FREEZE     = 5'h01;
    localparam logic [4:0]  ACT_STOP       = 5'h02;
    localparam logic [4:0]  ACT_JOG        = 5'h03;
    localparam logic [4:0]  ACT_MAX_SPEED  = 5'h04;
    localparam logic [4:0]  ACT_STOP_TRIP  = 5'h05;
    localparam logic [4:0]  ACT_SETUP1     = 5'h07;
    localparam logic [4:0]  ACT_SETUP4     = 5'h0a;
    localparam logic [4:0]  ACT_OVR_REL    = 5'h14;

    // End-of-timeout policy
    localparam logic        POL_HOLD       = 1'b0;
    localparam logic        POL_RESUME     = 1'b1;

    // Status / interrupt bit positions
    localparam int          EV_TIMEOUT     = 0;
    localparam int          EV_RECOVER     = 1;
    localparam int          EV_REJECT      = 2;
    localparam int          ST_LOST        = 2;
    localparam int          ST_WARN        = 3;

    localparam logic [1:0]  SETUP_RST      = 2'h0;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;

    typedef enum logic [1:0] {
        FCTM_RUN,
        FCTM_LOST,
        FCTM_HOLD
    } fctm_state_t;

endpackage : fctm_pkg

// File: fctm_remote_ctrl.sv
// Model of the remote network controller refreshing the drive inputs.
// Assumes aclk of the monitor; sends one-cycle strobes, one line at a time.
`timescale 1ns/10ps
module fctm_remote_ctrl
(
    // Clock, reset, enable
    input wire logic  aclk,
    input wire logic  aresetn,
    input wire logic  enable,
    // Update strobes
    output logic [5:0] net_in
);
    logic [7:0] gap_reg;
    logic [2:0] sel_reg;
    // Rotating lines with uneven gaps, so every input restarts the timer
    always_ff @(posedge aclk)
    begin
        net_in <= 6'h00;
        if (!aresetn || !enable)
        begin
            gap_reg <= 8'h10;
            sel_reg <= 3'h0;
        end
        else if (gap_reg == 8'h00)
        begin
            net_in  <= 6'h01 << sel_reg;
            sel_reg <= (sel_reg == 3'h5) ? 3'h0 : sel_reg + 3'h1;
            gap_reg <= 8'h20 + {5'h00, sel_reg} * 8'h07;
        end
        else
            gap_reg <= gap_reg - 8'h01;
    end
endmodule : fctm_remote_ctrl
